/* rtl/snvf_defines.svh */
`ifndef SNVF_DEFINES_SVH
`define SNVF_DEFINES_SVH
// Behaviour
// - device answers only while chip select low
// - chip select high enters standby
// - serial input sampled on clock rise
// - serial output changes on clock fall
// - pause freezes transfer, resumes where stopped
// - slave only, modes zero and three
// - normal reads and writes need no waits
// - address register holds seventeen bits
// - busy line low during store or recall
// - after store drive line high briefly
// - external low on busy line requests store
// - store copies whole array in parallel
// - ready flag shows busy during operations
// - array access refused while operation runs
// - two protect bits guard quarter, half, all
// - protection by pin and disable command
// - decode store, recall, autosave off, on
// - power fail with autosave enabled stores
// - burst address increments and wraps to zero
// - conditional stores skipped without prior write

// opcodes
`define SNVF_OP_WRSR 8'h01
`define SNVF_OP_WRITE 8'h02
`define SNVF_OP_READ 8'h03
`define SNVF_OP_WRITE_DISABLE 8'h04
`define SNVF_OP_RDSR 8'h05
`define SNVF_OP_WREN 8'h06
`define SNVF_OP_FAST_READ 8'h0b
`define SNVF_OP_STORE 8'h3c
`define SNVF_OP_RECALL 8'h60
`define SNVF_OP_AUTOSAVE_EN 8'h59
`define SNVF_OP_AUTOSAVE_DIS 8'h19
// status register fields
`define SNVF_SR_RDY 0
`define SNVF_SR_WEN 1
`define SNVF_SR_BP_LO 2
`define SNVF_SR_BP_HI 3
// block protect codes
`define SNVF_BP_QUARTER 2'h1
`define SNVF_BP_HALF 2'h2
`define SNVF_BP_ALL 2'h3
`define SNVF_BP_TOP_QUARTER 2'h3
// framing
`define SNVF_BIT_LAST 3'h7
`define SNVF_ADDR_LAST 2'h2
// pin levels at reset: cs_n sck si hold_n wp_n busy_in power_fail
`define SNVF_PIN_IDLE 7'h4e
// timing
`define SNVF_CLK_MHZ 100
`define SNVF_STORE_NS 8000000
`define SNVF_RECALL_NS 200000
`define SNVF_DRIVE_NS 100
`endif

/* rtl/snvf_pkg.sv */
package snvf_pkg;
  // raw pins, all asynchronous to mclk
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic store_busy_line_in;
    logic power_fail;
  } snvf_pins_t;

  typedef enum logic [2:0] {
    snvf_s_opcode, snvf_s_addr, snvf_s_dummy, snvf_s_wdata,
    snvf_s_rdata, snvf_s_wsr, snvf_s_rsr, snvf_s_ignore
  } snvf_spi_st_t;

  typedef enum logic [1:0] {
    snvf_nv_idle, snvf_nv_run, snvf_nv_drive
  } snvf_nv_st_t;
endpackage

/* rtl/snvf_top.sv */
`include "snvf_defines.svh"

module snvf_top
  import snvf_pkg::*;
#(
  parameter int ADDR_W = 17,
  parameter int CNT_W = 24,
  parameter int STORE_CYC = `SNVF_STORE_NS * `SNVF_CLK_MHZ / 1000,
  parameter int RECALL_CYC = `SNVF_RECALL_NS * `SNVF_CLK_MHZ / 1000,
  parameter int DRIVE_CYC = `SNVF_DRIVE_NS * `SNVF_CLK_MHZ / 1000
)(
  input wire logic mclk,
  input wire logic rst,
  input wire snvf_pins_t pins_in,
  input wire logic [7:0] mem_rdata,
  output logic so,
  output logic so_oe,
  output logic store_busy_line_out,
  output logic store_busy_line_oe,
  output logic standby,
  output logic ready_busy,
  output logic [7:0] status,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic nv_store,
  output logic nv_recall
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = $bits(snvf_pins_t);
  localparam logic [PIN_W-1:0] PIN_IDLE = `SNVF_PIN_IDLE;
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] sync_ff;
  snvf_pins_t pin_s;

  assign raw = pins_in;
  assign pin_s = sync_ff;

  // two flops per pin before any logic
  for (genvar i = 0; i < PIN_W; i++)
  begin : g_sync
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
      begin
        meta_ff[i] <= PIN_IDLE[i];
        sync_ff[i] <= PIN_IDLE[i];
      end
      else
      begin
        meta_ff[i] <= raw[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  // ----------------------------------------
  // serial clock edges
  // ----------------------------------------
  logic sck_d_ff;
  logic rise;
  logic fall;
  logic active;

  // edges count only while selected and not paused
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sck_d_ff <= 1'b0;
    else
      sck_d_ff <= pin_s.sck;
  end

  assign active = !pin_s.cs_n && pin_s.hold_n;
  assign rise = active && pin_s.sck && !sck_d_ff;
  assign fall = active && !pin_s.sck && sck_d_ff;

  // ----------------------------------------
  // shift-in and framing
  // ----------------------------------------
  snvf_spi_st_t st_ff;
  snvf_nv_st_t nv_st_ff;
  logic [2:0] bit_ff;
  logic [6:0] rx_ff;
  logic [1:0] acnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic fast_ff;
  logic wr_ff;
  logic wen_ff;
  logic [1:0] bp_ff;
  logic autosave_en_ff;
  logic dirty_ff;
  logic [7:0] byte_in;
  logic byte_done;
  logic op_done;
  logic busy;
  logic prot;
  logic wr_commit;
  logic fetch;
  logic [ADDR_W-1:0] fetch_addr;
  logic [ADDR_W-1:0] addr_asm;
  logic [7:0] status_w;

  assign byte_in = {rx_ff, pin_s.si};
  assign byte_done = rise && (bit_ff == `SNVF_BIT_LAST);
  assign op_done = byte_done && (st_ff == snvf_s_opcode);
  assign addr_asm = {addr_ff[ADDR_W-9:0], byte_in};
  assign busy = (nv_st_ff == snvf_nv_run);

  // bit counter and receive shifter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bit_ff <= 3'h0;
      rx_ff <= 7'h00;
    end
    else if (pin_s.cs_n)
      bit_ff <= 3'h0;
    else if (rise)
    begin
      bit_ff <= bit_ff + 3'h1;
      rx_ff <= byte_in[6:0];
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  // decoder state, address and burst counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= snvf_s_opcode;
      acnt_ff <= 2'h0;
      addr_ff <= '0;
      fast_ff <= 1'b0;
      wr_ff <= 1'b0;
    end
    else if (pin_s.cs_n)
      st_ff <= snvf_s_opcode;
    else if (byte_done)
    begin
      case (st_ff)
        snvf_s_opcode:
        begin
          acnt_ff <= 2'h0;
          fast_ff <= (byte_in == `SNVF_OP_FAST_READ);
          wr_ff <= (byte_in == `SNVF_OP_WRITE);
          case (byte_in)
            `SNVF_OP_READ, `SNVF_OP_FAST_READ, `SNVF_OP_WRITE:
              st_ff <= busy ? snvf_s_ignore : snvf_s_addr;
            `SNVF_OP_RDSR:
              st_ff <= snvf_s_rsr;
            `SNVF_OP_WRSR:
              st_ff <= snvf_s_wsr;
            default:
              st_ff <= snvf_s_ignore;
          endcase
        end
        snvf_s_addr:
        begin
          addr_ff <= addr_asm;
          acnt_ff <= acnt_ff + 2'h1;
          if (acnt_ff == `SNVF_ADDR_LAST)
          begin
            if (wr_ff)
              st_ff <= snvf_s_wdata;
            // fast read takes a dummy byte
            else if (fast_ff)
              st_ff <= snvf_s_dummy;
            else
              st_ff <= snvf_s_rdata;
          end
        end
        snvf_s_dummy:
          st_ff <= snvf_s_rdata;
        snvf_s_wdata, snvf_s_rdata:
          addr_ff <= addr_ff + ADDR_W'(1);
        default:
          st_ff <= st_ff;
      endcase
    end
  end

  // ----------------------------------------
  // protection and configuration
  // ----------------------------------------
  // protected region from protect bits
  always_comb
  begin
    case (bp_ff)
      `SNVF_BP_QUARTER:
        prot = (addr_ff[ADDR_W-1 -: 2] == `SNVF_BP_TOP_QUARTER);
      `SNVF_BP_HALF:
        prot = addr_ff[ADDR_W-1];
      `SNVF_BP_ALL:
        prot = 1'b1;
      default:
        prot = 1'b0;
    endcase
  end

  // pin and latch both gate writes
  assign wr_commit = byte_done && (st_ff == snvf_s_wdata) && wen_ff
                     && pin_s.wp_n && !prot && !busy;

  // write enable latch
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wen_ff <= 1'b0;
    else if (op_done && byte_in == `SNVF_OP_WREN)
      wen_ff <= 1'b1;
    else if (op_done && byte_in == `SNVF_OP_WRITE_DISABLE)
      wen_ff <= 1'b0;
  end

  // block protect bits, written by status write
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bp_ff <= 2'h0;
    else if (byte_done && st_ff == snvf_s_wsr && wen_ff && pin_s.wp_n)
      bp_ff <= byte_in[`SNVF_SR_BP_HI:`SNVF_SR_BP_LO];
  end

  // autosave enable flag
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      autosave_en_ff <= 1'b1;
    else if (op_done && byte_in == `SNVF_OP_AUTOSAVE_EN)
      autosave_en_ff <= 1'b1;
    else if (op_done && byte_in == `SNVF_OP_AUTOSAVE_DIS)
      autosave_en_ff <= 1'b0;
  end

  // status image
  always_comb
  begin
    status_w = 8'h00;
    status_w[`SNVF_SR_RDY] = busy;
    status_w[`SNVF_SR_WEN] = wen_ff;
    status_w[`SNVF_SR_BP_HI:`SNVF_SR_BP_LO] = bp_ff;
  end

  // ----------------------------------------
  // array port and read path
  // ----------------------------------------
  logic ld_ff;
  logic ld2_ff;
  logic rd_ok_ff;
  logic [7:0] tx_ff;

  // next byte to prefetch for the read stream
  always_comb
  begin
    fetch = 1'b0;
    fetch_addr = addr_ff;
    if (byte_done && st_ff == snvf_s_addr && acnt_ff == `SNVF_ADDR_LAST
        && !wr_ff && !fast_ff)
    begin
      fetch = 1'b1;
      fetch_addr = addr_asm;
    end
    else if (byte_done && st_ff == snvf_s_dummy)
      fetch = 1'b1;
    else if (byte_done && st_ff == snvf_s_rdata)
    begin
      fetch = 1'b1;
      fetch_addr = addr_ff + ADDR_W'(1);
    end
  end

  // strobes follow the byte with no wait
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mem_addr <= '0;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      ld_ff <= 1'b0;
      ld2_ff <= 1'b0;
      rd_ok_ff <= 1'b0;
    end
    else
    begin
      mem_addr <= wr_commit ? addr_ff : fetch_addr;
      mem_wdata <= byte_in;
      mem_we <= wr_commit;
      mem_re <= fetch && !busy;
      ld_ff <= fetch;
      ld2_ff <= ld_ff;
      rd_ok_ff <= mem_re;
    end
  end

  // transmit shifter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tx_ff <= 8'h00;
    else if (ld2_ff)
      tx_ff <= rd_ok_ff ? mem_rdata : 8'h00;
    else if (byte_done && (op_done || st_ff == snvf_s_rsr))
      tx_ff <= status_w;
    else if (fall)
      tx_ff <= {tx_ff[6:0], 1'b0};
  end

  // serial output pin
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      // data returned only in output states
      so_oe <= active && (st_ff == snvf_s_rdata || st_ff == snvf_s_rsr);
      if (pin_s.cs_n)
        so <= 1'b0;
      else if (fall && (st_ff == snvf_s_rdata || st_ff == snvf_s_rsr))
        so <= tx_ff[7];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      standby <= 1'b1;
    else
      standby <= pin_s.cs_n;
  end

  // ----------------------------------------
  // store and recall engine
  // ----------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic is_store_ff;
  logic sw_store;
  logic sw_recall;
  logic hw_req;
  logic pf_req;
  logic start_store;
  logic start_recall;
  logic [1:0] oe_hist_ff;

  // busy line drive history, our own low is still in the synchroniser
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      oe_hist_ff <= 2'h0;
    else
      oe_hist_ff <= {oe_hist_ff[0], store_busy_line_oe};
  end

  assign sw_store = op_done && byte_in == `SNVF_OP_STORE;
  assign sw_recall = op_done && byte_in == `SNVF_OP_RECALL;
  // external low is a store request
  assign hw_req = !pin_s.store_busy_line_in && !store_busy_line_oe
                  && (oe_hist_ff == 2'h0);
  assign pf_req = pin_s.power_fail && autosave_en_ff;
  // conditional stores need a prior write
  assign start_store = (nv_st_ff == snvf_nv_idle)
                       && (sw_store || ((hw_req || pf_req) && dirty_ff));
  assign start_recall = (nv_st_ff == snvf_nv_idle) && sw_recall && !start_store;

  // operation sequencer and timer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      nv_st_ff <= snvf_nv_idle;
      cnt_ff <= '0;
      is_store_ff <= 1'b0;
    end
    else
    begin
      case (nv_st_ff)
        snvf_nv_idle:
        begin
          is_store_ff <= start_store;
          if (start_store)
          begin
            nv_st_ff <= snvf_nv_run;
            cnt_ff <= CNT_W'(STORE_CYC - 1);
          end
          else if (start_recall)
          begin
            nv_st_ff <= snvf_nv_run;
            cnt_ff <= CNT_W'(RECALL_CYC - 1);
          end
        end
        snvf_nv_run:
        begin
          cnt_ff <= cnt_ff - CNT_W'(1);
          if (cnt_ff == '0)
          begin
            nv_st_ff <= is_store_ff ? snvf_nv_drive : snvf_nv_idle;
            cnt_ff <= CNT_W'(DRIVE_CYC - 1);
          end
        end
        snvf_nv_drive:
        begin
          cnt_ff <= cnt_ff - CNT_W'(1);
          if (cnt_ff == '0)
            nv_st_ff <= snvf_nv_idle;
        end
        default:
          nv_st_ff <= snvf_nv_idle;
      endcase
    end
  end

  // dirty set by writes, set wins over clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dirty_ff <= 1'b0;
    else
      dirty_ff <= wr_commit || (dirty_ff && !(start_store || start_recall));
  end

  // busy line drive, flags and array strobes
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      store_busy_line_oe <= 1'b0;
      store_busy_line_out <= 1'b0;
      ready_busy <= 1'b0;
      status <= 8'h00;
      nv_store <= 1'b0;
      nv_recall <= 1'b0;
    end
    else
    begin
      // low while running, then high after a store, then released
      store_busy_line_oe <= (nv_st_ff != snvf_nv_idle);
      store_busy_line_out <= (nv_st_ff == snvf_nv_drive);
      ready_busy <= busy;
      status <= status_w;
      nv_store <= start_store;
      nv_recall <= start_recall;
    end
  end

endmodule // snvf_top

/* verification/snvf_checker.sv */
// ----------
// port checks
// ----------
module snvf_checker
  import snvf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire snvf_pins_t pins_in,
  input wire logic so,
  input wire logic so_oe,
  input wire logic store_busy_line_out,
  input wire logic store_busy_line_oe,
  input wire logic standby,
  input wire logic ready_busy,
  input wire logic [7:0] status,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic nv_store
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // link side: select, edges, pause
  desel_quiet_a:
    assert property (pins_in.cs_n [*4] |=> !so_oe && !mem_we)
    else $error("output active while deselected");
  standby_entry_a:
    assert property ($rose(pins_in.cs_n) |-> ##[1:4] standby)
    else $error("standby not entered");
  write_edge_a:
    assert property (mem_we |-> pins_in.sck)
    else $error("write not tied to clock rise");
  so_edge_a:
    assert property ($changed(so) && $past(so_oe) && so_oe |-> !pins_in.sck)
    else $error("so moved outside clock low phase");
  pause_quiet_a:
    assert property (!pins_in.hold_n [*4] |=> !so_oe)
    else $error("so driven while paused");

  // store engine
  busy_low_a:
    assert property (nv_store |-> ##[0:2] store_busy_line_oe && !store_busy_line_out)
    else $error("busy line not pulled low");
  drive_high_a:
    assert property ($rose(store_busy_line_oe && store_busy_line_out) |->
      (store_busy_line_oe && store_busy_line_out) [*3] ##[1:8] !store_busy_line_oe)
    else $error("busy line drive high wrong");
  rdy_flag_a:
    assert property ($changed(ready_busy) |-> ##[0:1] status[0] == ready_busy)
    else $error("ready flag differs from busy");
  busy_refuse_a:
    assert property (ready_busy [*2] |-> !mem_we && !mem_re)
    else $error("array access while busy");
endmodule // snvf_checker

bind snvf_top snvf_checker chk (
  .mclk(mclk), .rst(rst), .pins_in(pins_in), .so(so), .so_oe(so_oe),
  .store_busy_line_out(store_busy_line_out), .store_busy_line_oe(store_busy_line_oe),
  .standby(standby), .ready_busy(ready_busy), .status(status),
  .mem_we(mem_we), .mem_re(mem_re), .nv_store(nv_store)
);

/* verification/snvf_master.sv */
// ----------
// serial master model
// ----------
module snvf_master (
  input wire logic mclk,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol = 1'b0;
  logic [7:0] rx;
  // idle bus, deselected
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task sel();
    // start off the mclk edge so no pin moves on it
    @(posedge mclk);
    #1.3;
    sck = cpol;
    #62.5 cs_n = 1'b0;
    #62.5;
  endtask
  // bits out on si, msb first, read back at rise
  task xb(input logic [7:0] d, input int p);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si = d[i];
      if (i == p)
      begin
        #40 hold_n = 1'b0;
        #400 hold_n = 1'b1;
      end
      #62.5 sck = 1'b1;
      rx[i] = so;
      #62.5;
    end
  endtask
  // end frame, si no longer valid
  task desel();
    sck = cpol;
    #62.5 cs_n = 1'b1;
    si = ~si;
    #250;
  endtask
endmodule // snvf_master

/* verification/tb_top.sv */
// ----------
// testbench
// ----------
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [16:0] a;
    logic [7:0] d;
    logic fast;
    logic mode;
  } snvf_row_t;
  snvf_row_t rows [6] = '{'{17'h00000, 8'h5a, 1'b0, 1'b0}, '{17'h1ffff, 8'ha5, 1'b1, 1'b1},
    '{17'h10000, 8'h3c, 1'b0, 1'b1}, '{17'h0ffff, 8'hc3, 1'b1, 1'b0},
    '{17'h12345, 8'h01, 1'b0, 1'b0}, '{17'h1abcd, 8'hfe, 1'b1, 1'b1}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic pwr_fail = 1'b0;
  logic ext_low = 1'b0;
  logic cs_n, sck, si, hold_n, so, so_oe, bsy_out, bsy_oe, standby, ready_busy;
  logic mem_we, mem_re, nv_store, nv_recall;
  logic [7:0] status, mem_wdata, q;
  logic [7:0] mem_rdata = 8'h00;
  logic [16:0] mem_addr, bnd;
  logic [7:0] mem [0:131071];
  int fail_count = 0, checks_done = 0, we_n = 0, st_n = 0, rc_n = 0, w, s;
  snvf_pkg::snvf_pins_t pins;

  // pins, open-drain busy wire with weak pull-up
  assign pins = '{cs_n, sck, si, hold_n, wp_n, (bsy_oe ? bsy_out : 1'b1) & ~ext_low, pwr_fail};
  always #5 mclk = ~mclk;

  snvf_top #(.STORE_CYC(2000), .RECALL_CYC(1000), .DRIVE_CYC(4)) uut (
    .mclk(mclk), .rst(rst), .pins_in(pins), .mem_rdata(mem_rdata), .so(so), .so_oe(so_oe),
    .store_busy_line_out(bsy_out), .store_busy_line_oe(bsy_oe), .standby(standby),
    .ready_busy(ready_busy), .status(status), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .nv_store(nv_store), .nv_recall(nv_recall));
  // a released so pin reads as the inverse, nothing pulls it
  snvf_master m (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so(so_oe ? so : ~so));

  // array model, data the cycle after a read strobe; event counters
  always @(posedge mclk)
  begin
    if (mem_re) mem_rdata <= mem[mem_addr];
    if (mem_we) mem[mem_addr] <= mem_wdata;
    we_n <= we_n + int'(mem_we);
    st_n <= st_n + int'(nv_store);
    rc_n <= rc_n + int'(nv_recall);
  end

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task complete_run();
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // opcode with an optional second byte
  task cmd(input logic [7:0] op, input logic [7:0] d, input int n);
    m.sel();
    m.xb(op, -1);
    if (n > 0) m.xb(d, -1);
    m.desel();
  endtask
  task hdr(input logic [7:0] op, input logic [16:0] a);
    m.sel();
    m.xb(op, -1);
    m.xb({7'h00, a[16]}, -1);
    m.xb(a[15:8], -1);
    m.xb(a[7:0], -1);
  endtask
  task wr(input logic [16:0] a, input logic [7:0] d, input int n);
    hdr(8'h02, a);
    for (int i = 0; i < n; i++) m.xb(d + 8'(i), -1);
    m.desel();
  endtask
  // fast read adds a dummy byte
  task rd(input logic [16:0] a, input logic f, input int p);
    hdr(f ? 8'h0b : 8'h03, a);
    if (f) m.xb(8'h00, -1);
    m.xb(8'h00, p);
    q = m.rx;
    m.desel();
  endtask
  task idle();
    repeat (20) @(posedge mclk);
    for (int i = 0; i < 3000 && (ready_busy || bsy_oe); i++) @(posedge mclk);
    chk("idle", {ready_busy, bsy_oe}, 0);
  endtask
  // busy wire pulled low (k 0) or supply failing (k 1)
  task pulse(input int k);
    @(posedge mclk);
    ext_low <= (k == 0);
    pwr_fail <= (k == 1);
    repeat (10) @(posedge mclk);
    ext_low <= 1'b0;
    pwr_fail <= 1'b0;
    idle();
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("standby", standby, 1);
    chk("status", status, 0);
    chk("busy_oe", bsy_oe, 0);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h05, 8'h00, 1);
    chk("rdsr", m.rx, 8'h02);
    foreach (rows[i])
    begin
      m.cpol = rows[i].mode;
      wr(rows[i].a, rows[i].d, 1);
      rd(rows[i].a, rows[i].fast, -1);
      chk("readback", q, rows[i].d);
      chk("array", mem[rows[i].a], rows[i].d);
    end
    rd(17'h00000, 1'b0, 3);
    chk("paused", q, 8'h5a);
    wr(17'h1ffff, 8'h70, 3);
    chk("wrap0", mem[0], 8'h71);
    chk("wrap1", mem[1], 8'h72);
    w = we_n;
    m.sel();
    m.xb(8'h02, -1);
    m.xb(8'h00, -1);
    m.desel();
    cmd(8'h05, 8'h00, 1);
    chk("abort_we", we_n - w, 0);
    chk("abort_sr", m.rx, 8'h02);
    cmd(8'h04, 8'h00, 0);
    w = we_n;
    wr(17'h00100, 8'h11, 1);
    chk("write_disable_cmd", we_n - w, 0);
    cmd(8'h06, 8'h00, 0);
    @(posedge mclk) wp_n <= 1'b0;
    wr(17'h00100, 8'h11, 1);
    chk("wp_pin", we_n - w, 0);
    @(posedge mclk) wp_n <= 1'b1;
    for (int b = 1; b < 4; b++)
    begin
      bnd = (b == 1) ? 17'h18000 : (b == 2) ? 17'h10000 : 17'h00000;
      cmd(8'h01, {4'h0, b[1:0], 2'h0}, 1);
      cmd(8'h06, 8'h00, 0);
      cmd(8'h05, 8'h00, 1);
      chk("bp_sr", m.rx, {4'h0, b[1:0], 2'h2});
      w = we_n;
      wr(bnd, 8'h22, 1);
      chk("bp_hit", we_n - w, 0);
      wr(bnd - 17'h1, 8'h23, 1);
      chk("bp_edge", we_n - w, (b == 3) ? 0 : 1);
    end
    cmd(8'h01, 8'h00, 1);
    cmd(8'h06, 8'h00, 0);
    s = st_n;
    cmd(8'h3c, 8'h00, 0);
    chk("rdy", ready_busy, 1);
    chk("wire_low", pins.store_busy_line_in, 0);
    w = we_n;
    wr(17'h00200, 8'h33, 1);
    chk("busy_we", we_n - w, 0);
    idle();
    chk("sw_store", st_n - s, 1);
    chk("wire_up", pins.store_busy_line_in, 1);
    pulse(0);
    chk("clean_hw", st_n - s, 1);
    wr(17'h00300, 8'h44, 1);
    pulse(0);
    chk("hw_store", st_n - s, 2);
    w = rc_n;
    cmd(8'h60, 8'h00, 0);
    idle();
    chk("recall", rc_n - w, 1);
    cmd(8'h19, 8'h00, 0);
    wr(17'h00400, 8'h55, 1);
    pulse(1);
    chk("save_off", st_n - s, 2);
    cmd(8'h59, 8'h00, 0);
    pulse(1);
    chk("save_on", st_n - s, 3);
    complete_run();
  end

  // watchdog, well beyond the expected run time
  initial
  begin
    #600us;
    fail_count++;
    complete_run();
  end
endmodule // tb_top
